// ==== logic/mce_cfg.svh ====
// Register indices, reset values and fixed counts of the calibration engine.
// Included by the divider, channel and top design files; definitions only.
`ifndef MCE_CFG_SVH
`define MCE_CFG_SVH
`define MCE_IDX_CMD 6'h00
`define MCE_IDX_STAT 6'h01
`define MCE_IDX_NCNT 6'h02
`define MCE_IDX_SETL 6'h03
`define MCE_IDX_DCOFF 6'h04
`define MCE_IDX_GAIN 6'h07
`define MCE_IDX_ACOFF 6'h0A
`define MCE_IDX_IZX 6'h18
`define MCE_IDX_TEMPERATURE_OFFSET 6'h37
`define MCE_IDX_VZX 6'h3A
`define MCE_IDX_SCALE 6'h3F
`define MCE_RST_ZX 24'h100000
`define MCE_RST_TEMPERATURE_OFFSET 24'hD53998
`define MCE_RST_SCALE 24'h4CCCCC
`define MCE_RST_GAIN 24'h400000
`define MCE_RST_NCNT 16'h0FA0
`define MCE_RST_SETL 16'h001E
`define MCE_VREF_RMS 24'h4CCCCC
`define MCE_ACOFF_MAX 24'hFFFFFF
`define MCE_STAT_CONVERSION_DONE_FLAG 0
`define MCE_STAT_GINV 1
`define MCE_STAT_BUSY 2
`define MCE_ZX_WIN 8'hFF
`define MCE_DIV_STEPS 6'h30
`endif

// ==== logic/mce_pkg.sv ====
// Types and shared arithmetic of the calibration engine.
// Assumes nothing of its surroundings.
`default_nettype none
package mce_pkg;
  typedef enum logic [1:0] {
    MCE_CAL_DC = 2'h0,
    MCE_CAL_AC = 2'h1,
    MCE_CAL_GAIN = 2'h2,
    MCE_CAL_NONE = 2'h3
  } mce_kind_t;
  typedef struct packed {mce_kind_t kind; logic [1:0] chan;} mce_cmd_t;
  typedef struct packed {logic act; logic wr; logic hit; logic [5:0] idx;} mce_ph_t;
  typedef enum logic [2:0] {
    MCE_ST_IDLE = 3'h0,
    MCE_ST_SETTLE = 3'h1,
    MCE_ST_ACCUM = 3'h3,
    MCE_ST_AVG = 3'h2,
    MCE_ST_GDIV = 3'h6,
    MCE_ST_DONE = 3'h7
  } mce_state_t;

  function automatic logic [23:0] mce_sat24(input logic [27:0] v);
    if (v[27] && !(&v[26:23])) return 24'h800000;
    if (!v[27] && (|v[26:23])) return 24'h7FFFFF;
    return v[23:0];
  endfunction : mce_sat24

  function automatic logic [23:0] mce_abs24(input logic [23:0] v);
    return v[23] ? 24'h000000 - v : v;
  endfunction : mce_abs24
endpackage : mce_pkg
`default_nettype wire

// ==== logic/mce_divider.sv ====
// Unsigned restoring divider, one quotient bit per enabled clock.
// Assumes start is a one-cycle pulse and inputs hold only at that edge.
`timescale 1ns/1ps
`default_nettype none
`include "mce_cfg.svh"
module mce_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [47:0] num,
  input wire logic [39:0] den,
  output logic done,
  output logic [23:0] quo,
  output logic ovf
);
  logic [47:0] n_q;
  logic [39:0] den_q;
  logic [40:0] r_q;
  logic [47:0] q_q;
  logic [5:0] cnt_q;
  logic [40:0] r_sh;
  logic [41:0] diff;

  assign r_sh = {r_q[39:0], n_q[47]};
  assign diff = {1'b0, r_sh} - {2'b00, den_q};
  assign quo = q_q[23:0];
  assign ovf = |q_q[47:24];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_q <= 48'h000000000000;
      den_q <= 40'h0000000000;
      r_q <= 41'h00000000000;
      q_q <= 48'h000000000000;
      cnt_q <= 6'h00;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        n_q <= num;
        den_q <= den;
        r_q <= 41'h00000000000;
        q_q <= 48'h000000000000;
        cnt_q <= `MCE_DIV_STEPS;
      end else if (cnt_q != 6'h00) begin
        n_q <= {n_q[46:0], 1'b0};
        r_q <= diff[41] ? r_sh : diff[40:0];
        q_q <= {q_q[46:0], ~diff[41]};
        cnt_q <= cnt_q - 6'h01;
        done <= (cnt_q == 6'h01);
      end
    end
  end
endmodule : mce_divider
`default_nettype wire

// ==== logic/mce_chan.sv ====
// One channel's correction path: DC offset, gain, zero-cross gate.
// Assumes owr_stb marks each new raw sample, one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "mce_cfg.svh"
module mce_chan (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic owr_stb,
  input wire logic [23:0] raw,
  input wire logic [23:0] dcoff,
  input wire logic [23:0] gain,
  input wire logic [23:0] zx_thr,
  output logic [23:0] corr,
  output logic zx_en
);
  logic [24:0] sum;
  logic [49:0] prod;
  logic [23:0] peak_q;
  logic [7:0] win_q;
  logic [23:0] mag;

  assign sum = {raw[23], raw} + {dcoff[23], dcoff};
  assign prod = $signed(sum) * $signed({1'b0, gain});
  assign mag = mce_pkg::mce_abs24(corr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr <= 24'h000000;
    end else if (ce && owr_stb) begin
      corr <= mce_pkg::mce_sat24(prod[49:22]);
    end
  end

  // Peak over a window enables zero-cross detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peak_q <= 24'h000000;
      win_q <= 8'h00;
      zx_en <= 1'b0;
    end else if (ce && owr_stb) begin
      win_q <= win_q + 8'h01;
      if (win_q == `MCE_ZX_WIN) begin
        zx_en <= (peak_q > zx_thr);
        peak_q <= mag;
      end else if (mag > peak_q) begin
        peak_q <= mag;
      end
    end
  end
endmodule : mce_chan
`default_nettype wire

// ==== logic/mce_top.sv ====
// Calibration engine of a three-channel metering front end, AHB-Lite slave.
// Assumes one AHB-Lite master, samples synchronous to hclk, owr_stb per word.
`timescale 1ns/1ps
`default_nettype none
`include "mce_cfg.svh"

// Operation
// - Temperature result is raw temperature plus the signed 8.16 offset.
// - Scale register resets to 0.6, signed fraction, drives current gain target.
// - Current gain calibration writes scale divided by measured current RMS.
// - Voltage zero-cross works only when peak exceeds voltage threshold.
// - Current zero-cross works only when peak exceeds current threshold.
// - DC offset and gain correct samples early, feeding samp_corr and AC calibration.
// - AC offset affects only the current mean-square result.
// - Every channel owns its offset and gain registers.
// - Calibration averages the programmed number of output words, one word when that number is zero.
// - Calibration lasts settling count plus sample count output words.
// - Completion sets the data-ready flag; overflow may set other flags.
// - DC calibration stores the negated average and adds it later.
// - AC calibration stores the mean square and subtracts it later.
// - AC offset saturates at its full 24-bit code.
// - Voltage gain calibration writes 0.6 divided by measured voltage RMS.
// - Gain above four is invalid and is not written.
module mce_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic owr_stb,
  input wire logic [2:0][23:0] samp_raw,
  input wire logic [2:0][23:0] rms_in,
  input wire logic [1:0][23:0] ms_in,
  input wire logic [23:0] temp_raw,
  output logic [2:0][23:0] samp_corr,
  output logic [2:0] zx_en,
  output logic [1:0][23:0] i_ms_corr,
  output logic [23:0] temp_result,
  output logic cal_busy
);
  mce_pkg::mce_ph_t ph_q;
  logic rd_done_q;
  logic [31:0] rd_mux;
  logic wr_en;
  logic cmd_wr;
  logic stat_wr;
  mce_pkg::mce_cmd_t cmd_new;
  logic cmd_ok;

  logic [15:0] ncnt_q;
  logic [15:0] setl_q;
  logic [23:0] izx_q;
  logic [23:0] vzx_q;
  logic [23:0] temperature_offset_q;
  logic [23:0] scale_q;
  logic [2:0][23:0] dcoff_q;
  logic [2:0][23:0] gain_q;
  logic [1:0][23:0] acoff_q;
  logic conversion_done_flag_q;
  logic ginv_q;

  mce_pkg::mce_state_t st_q;
  mce_pkg::mce_cmd_t cmd_q;
  logic [15:0] cnt_q;
  logic [15:0] n_eff;
  logic [47:0] acc_q;
  logic [47:0] samp_val;
  logic [47:0] sq;
  logic [23:0] avg_q;
  logic bad_q;
  logic div_go_q;
  logic [47:0] div_num;
  logic [39:0] div_den;
  logic [23:0] gnum;
  logic div_done;
  logic [23:0] div_quo;
  logic div_ovf;
  logic ac_sel;
  logic [24:0] t_sum;

  // Bus side
  assign hresp = 1'b0;
  assign hreadyout = !(ph_q.act && !ph_q.wr && !rd_done_q);
  assign wr_en = ph_q.act && ph_q.wr && ph_q.hit && hready;
  assign cmd_wr = wr_en && (ph_q.idx == `MCE_IDX_CMD);
  assign stat_wr = wr_en && (ph_q.idx == `MCE_IDX_STAT);
  assign cmd_new = mce_pkg::mce_cmd_t'(hwdata[3:0]);
  assign cmd_ok = (cmd_new.chan != 2'h3) && (cmd_new.kind != mce_pkg::MCE_CAL_NONE)
    && !(cmd_new.kind == mce_pkg::MCE_CAL_AC && cmd_new.chan == 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= '0;
      rd_done_q <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      if (hready) begin
        ph_q.act <= hsel && htrans[1];
        ph_q.wr <= hwrite;
        ph_q.hit <= (haddr[31:8] == 24'h000000);
        ph_q.idx <= haddr[7:2];
        rd_done_q <= 1'b0;
      end else if (ph_q.act && !ph_q.wr) begin
        // Read data settles one cycle after the address phase
        rd_done_q <= 1'b1;
        hrdata <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (ph_q.hit) begin
      case (ph_q.idx)
        `MCE_IDX_CMD: rd_mux = {28'h0000000, cmd_q};
        `MCE_IDX_STAT: rd_mux = {29'h00000000, cal_busy, ginv_q, conversion_done_flag_q};
        `MCE_IDX_NCNT: rd_mux = {16'h0000, ncnt_q};
        `MCE_IDX_SETL: rd_mux = {16'h0000, setl_q};
        `MCE_IDX_IZX: rd_mux = {8'h00, izx_q};
        `MCE_IDX_TEMPERATURE_OFFSET: rd_mux = {8'h00, temperature_offset_q};
        `MCE_IDX_VZX: rd_mux = {8'h00, vzx_q};
        `MCE_IDX_SCALE: rd_mux = {8'h00, scale_q};
        default: begin
          for (int k = 0; k < 3; k++) begin
            if (ph_q.idx == `MCE_IDX_DCOFF + 6'(k)) rd_mux = {8'h00, dcoff_q[k]};
            if (ph_q.idx == `MCE_IDX_GAIN + 6'(k)) rd_mux = {8'h00, gain_q[k]};
          end
          for (int k = 0; k < 2; k++) begin
            if (ph_q.idx == `MCE_IDX_ACOFF + 6'(k)) rd_mux = {8'h00, acoff_q[k]};
          end
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ncnt_q <= `MCE_RST_NCNT;
      setl_q <= `MCE_RST_SETL;
      izx_q <= `MCE_RST_ZX;
      vzx_q <= `MCE_RST_ZX;
      temperature_offset_q <= `MCE_RST_TEMPERATURE_OFFSET;
      scale_q <= `MCE_RST_SCALE;
    end else if (ce && wr_en) begin
      case (ph_q.idx)
        `MCE_IDX_NCNT: ncnt_q <= hwdata[15:0];
        `MCE_IDX_SETL: setl_q <= hwdata[15:0];
        `MCE_IDX_IZX: izx_q <= hwdata[23:0];
        `MCE_IDX_TEMPERATURE_OFFSET: temperature_offset_q <= hwdata[23:0];
        `MCE_IDX_VZX: vzx_q <= hwdata[23:0];
        `MCE_IDX_SCALE: scale_q <= hwdata[23:0];
        default: ;
      endcase
    end
  end

  // Per-channel calibration registers; engine write wins over bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcoff_q <= {3{24'h000000}};
      gain_q <= {3{`MCE_RST_GAIN}};
      acoff_q <= {2{24'h000000}};
    end else if (ce) begin
      if (wr_en) begin
        for (int k = 0; k < 3; k++) begin
          if (ph_q.idx == `MCE_IDX_DCOFF + 6'(k)) dcoff_q[k] <= hwdata[23:0];
          if (ph_q.idx == `MCE_IDX_GAIN + 6'(k)) gain_q[k] <= hwdata[23:0];
        end
        for (int k = 0; k < 2; k++) begin
          if (ph_q.idx == `MCE_IDX_ACOFF + 6'(k)) acoff_q[k] <= hwdata[23:0];
        end
      end
      if (st_q == mce_pkg::MCE_ST_DONE) begin
        case (cmd_q.kind)
          mce_pkg::MCE_CAL_DC: begin
            dcoff_q[cmd_q.chan] <= acc_q[47] ? mce_pkg::mce_sat24({4'h0, avg_q})
              : 24'h000000 - avg_q;
          end
          mce_pkg::MCE_CAL_AC: acoff_q[ac_sel] <= avg_q;
          mce_pkg::MCE_CAL_GAIN: begin
            if (!bad_q) gain_q[cmd_q.chan] <= avg_q;
          end
          default: ;
        endcase
      end
    end
  end

  // Status flags: hardware set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag_q <= 1'b0;
      ginv_q <= 1'b0;
    end else if (ce) begin
      if (stat_wr && hwdata[`MCE_STAT_CONVERSION_DONE_FLAG]) conversion_done_flag_q <= 1'b0;
      if (stat_wr && hwdata[`MCE_STAT_GINV]) ginv_q <= 1'b0;
      if (st_q == mce_pkg::MCE_ST_DONE) conversion_done_flag_q <= 1'b1;
      if (st_q == mce_pkg::MCE_ST_DONE && bad_q) ginv_q <= 1'b1;
    end
  end

  // Engine datapath
  assign cal_busy = (st_q != mce_pkg::MCE_ST_IDLE);
  assign n_eff = (ncnt_q == 16'h0000) ? 16'h0001 : ncnt_q;
  assign ac_sel = (cmd_q.chan == 2'h2);
  assign sq = $signed(samp_corr[cmd_q.chan]) * $signed(samp_corr[cmd_q.chan]);
  assign gnum = (cmd_q.chan == 2'h0) ? `MCE_VREF_RMS : scale_q;

  always_comb begin
    samp_val = 48'h000000000000;
    case (cmd_q.kind)
      mce_pkg::MCE_CAL_DC: samp_val = {{24{samp_raw[cmd_q.chan][23]}}, samp_raw[cmd_q.chan]};
      mce_pkg::MCE_CAL_AC: begin
        samp_val = {24'h000000, (|sq[47:46]) ? `MCE_ACOFF_MAX : sq[45:22]};
      end
      mce_pkg::MCE_CAL_GAIN: samp_val = {24'h000000, rms_in[cmd_q.chan]};
      default: samp_val = 48'h000000000000;
    endcase
  end

  always_comb begin
    if (st_q == mce_pkg::MCE_ST_GDIV) begin
      div_num = {2'b00, gnum, 22'h000000};
      div_den = {16'h0000, avg_q};
    end else begin
      div_num = acc_q[47] ? 48'h000000000000 - acc_q : acc_q;
      div_den = {24'h000000, n_eff};
    end
  end

  mce_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(div_go_q),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo),
    .ovf(div_ovf)
  );

  // Sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= mce_pkg::MCE_ST_IDLE;
      cmd_q <= '0;
      cnt_q <= 16'h0000;
      acc_q <= 48'h000000000000;
      div_go_q <= 1'b0;
    end else if (ce) begin
      div_go_q <= 1'b0;
      case (st_q)
        mce_pkg::MCE_ST_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            cmd_q <= cmd_new;
            cnt_q <= 16'h0000;
            acc_q <= 48'h000000000000;
            st_q <= (setl_q == 16'h0000) ? mce_pkg::MCE_ST_ACCUM : mce_pkg::MCE_ST_SETTLE;
          end
        end
        mce_pkg::MCE_ST_SETTLE: begin
          if (owr_stb) begin
            if (cnt_q + 16'h0001 == setl_q) begin
              cnt_q <= 16'h0000;
              st_q <= mce_pkg::MCE_ST_ACCUM;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        mce_pkg::MCE_ST_ACCUM: begin
          if (owr_stb) begin
            acc_q <= acc_q + samp_val;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q + 16'h0001 == n_eff) begin
              st_q <= mce_pkg::MCE_ST_AVG;
              div_go_q <= 1'b1;
            end
          end
        end
        mce_pkg::MCE_ST_AVG: begin
          if (div_done) begin
            if (cmd_q.kind == mce_pkg::MCE_CAL_GAIN) begin
              st_q <= mce_pkg::MCE_ST_GDIV;
              div_go_q <= 1'b1;
            end else begin
              st_q <= mce_pkg::MCE_ST_DONE;
            end
          end
        end
        mce_pkg::MCE_ST_GDIV: begin
          if (div_done) st_q <= mce_pkg::MCE_ST_DONE;
        end
        mce_pkg::MCE_ST_DONE: st_q <= mce_pkg::MCE_ST_IDLE;
        default: st_q <= mce_pkg::MCE_ST_IDLE;
      endcase
    end
  end

  // Division results
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg_q <= 24'h000000;
      bad_q <= 1'b0;
    end else if (ce && div_done) begin
      avg_q <= div_ovf ? `MCE_ACOFF_MAX : div_quo;
      bad_q <= (st_q == mce_pkg::MCE_ST_GDIV) && div_ovf;
    end
  end

  // Channel correction paths
  for (genvar g = 0; g < 3; g++) begin : g_chan
    mce_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .owr_stb(owr_stb),
      .raw(samp_raw[g]),
      .dcoff(dcoff_q[g]),
      .gain(gain_q[g]),
      .zx_thr((g == 0) ? vzx_q : izx_q),
      .corr(samp_corr[g]),
      .zx_en(zx_en[g])
    );
  end

  // Current mean square less AC offset, temperature plus offset
  assign t_sum = {temp_raw[23], temp_raw} + {temperature_offset_q[23], temperature_offset_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_ms_corr <= {2{24'h000000}};
      temp_result <= 24'h000000;
    end else if (ce) begin
      for (int k = 0; k < 2; k++) begin
        i_ms_corr[k] <= (ms_in[k] > acoff_q[k]) ? ms_in[k] - acoff_q[k] : 24'h000000;
      end
      temp_result <= mce_pkg::mce_sat24({{3{t_sum[24]}}, t_sum});
    end
  end
endmodule : mce_top
`default_nettype wire

// ==== logic/mce_top_end.sv ====
// Empty unit kept beside the engine top; it holds no logic.
// Assumes nothing of its surroundings.

// ==== testbench/mce_top_assertions.sv ====
// Port-level checks of the calibration engine, bound into mce_top.
// Assumes one AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module mce_top_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic owr_stb,
  input wire logic [1:0][23:0] ms_in,
  input wire logic [2:0][23:0] samp_corr,
  input wire logic [1:0][23:0] i_ms_corr,
  input wire logic cal_busy
);
  logic take;
  logic [7:0] busy_cyc_q;
  logic [7:0] busy_owr_q;
  assign take = hready && hsel && htrans[1] && ce;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Busy span in clocks and in output words, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cyc_q <= 8'h00;
      busy_owr_q <= 8'h00;
    end else if (!cal_busy) begin
      busy_cyc_q <= 8'h00;
      busy_owr_q <= 8'h00;
    end else begin
      busy_cyc_q <= busy_cyc_q + {7'h00, busy_cyc_q != 8'hFF};
      busy_owr_q <= busy_owr_q + {7'h00, owr_stb && busy_owr_q != 8'hFF};
    end
  end
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not OKAY");
  cal_start_a: assert property (ce && hready && !cal_busy && $past(take && hwrite && haddr == 32'h0)
      && hwdata[1:0] != 2'h3 && hwdata[3:2] != 2'h3 && hwdata[3:0] != 4'h4 |=> cal_busy)
    else $error("valid command did not start calibration");
  cal_length_a: assert property ($fell(cal_busy) |-> busy_cyc_q >= 8'h30 && busy_owr_q != 8'h00)
    else $error("calibration ended too early");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  rdata_hold_a: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data moved outside a read");
  corr_hold_a: assert property (!owr_stb |=> $stable(samp_corr))
    else $error("corrected sample moved without a word");
  ms_floor_a: assert property (ce |=> i_ms_corr[0] <= $past(ms_in[0]) && i_ms_corr[1] <= $past(ms_in[1]))
    else $error("mean square rose above its input");
endmodule : mce_top_checker
bind mce_top mce_top_checker i_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .owr_stb, .ms_in, .samp_corr, .i_ms_corr, .cal_busy);
`default_nettype wire

// ==== testbench/mce_front.sv ====
// Model of the measurement front end feeding one word per PERIOD clocks.
// Assumes the bench sets the levels; words are valid only in the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module mce_front #(parameter int PERIOD = 60) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0][23:0] raw_set,
  input wire logic [2:0][23:0] rms_set,
  output logic owr_stb,
  output logic [2:0][23:0] samp_raw,
  output logic [2:0][23:0] rms_in
);
  int cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 0;
      owr_stb <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      owr_stb <= (cnt_q == PERIOD - 1);
    end
  end
  // Inverse off the strobe so stale sampling shows
  assign samp_raw = owr_stb ? raw_set : ~raw_set;
  assign rms_in = owr_stb ? rms_set : ~rms_set;
endmodule : mce_front
`default_nettype wire

// ==== testbench/mce_top_bench.sv ====
// Self-checking bench of the calibration engine over AHB-Lite.
// Assumes mce_front as sample source and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("MISMATCH %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module mce_top_bench;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, owr_stb, cal_busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0][23:0] samp_raw, rms_in, raw_set, rms_set, samp_corr;
  logic [1:0][23:0] ms_in, i_ms_corr;
  logic [23:0] temp_raw, temp_result;
  logic [2:0] zx_en;
  int n_errors = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  mce_top i_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout, .hresp(), .owr_stb, .samp_raw, .rms_in, .ms_in, .temp_raw, .samp_corr, .zx_en,
    .i_ms_corr, .temp_result, .cal_busy);
  mce_front #(.PERIOD(60)) i_front (.hclk, .hresetn, .raw_set, .rms_set, .owr_stb, .samp_raw, .rms_in);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, idx, 2'h0};
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    rd = hrdata;
    if (k >= 20) begin
      n_errors++;
      $display("MISMATCH %0t bus answer timeout", $time);
    end
    @(posedge hclk);
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
  endtask : wr
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    `CHK(rd, exp)
  endtask : rd_chk
  task automatic wait_idle(output int n);
    int k;
    k = 0;
    n = (cal_busy === 1'b1 && owr_stb === 1'b1);
    while (cal_busy !== 1'b0 && k < 20000) begin
      @(posedge hclk);
      k++;
      if (cal_busy === 1'b1 && owr_stb === 1'b1) n++;
    end
    if (k >= 20000) begin
      n_errors++;
      $display("MISMATCH %0t calibration never ended", $time);
    end
  endtask : wait_idle
  task automatic cal(input logic [3:0] cmd, input int n_exp);
    int n;
    wr(6'h00, {28'h0000000, cmd});
    `CHK(cal_busy, 1'b1)
    wait_idle(n);
    if (n_exp > 0) `CHK(n, n_exp)
  endtask : cal
  task automatic t_regs;
    logic [5:0] idx [10] = '{6'h02, 6'h03, 6'h04, 6'h07, 6'h0A, 6'h18, 6'h37, 6'h3A, 6'h3F, 6'h20};
    logic [31:0] rv [10] = '{32'h0FA0, 32'h1E, 32'h0, 32'h400000, 32'h0, 32'h100000, 32'hD53998, 32'h100000,
      32'h4CCCCC, 32'h0};
    wr(6'h20, 32'hFFFFFFFF);
    for (int i = 0; i < 10; i++) rd_chk(idx[i], rv[i]);
    temp_raw <= 24'h010000;
    repeat (2) @(negedge hclk);
    `CHK(temp_result, 24'hD63998)
    @(posedge hclk);
    // Clock enable low freezes the temperature result
    ce <= 1'b0;
    temp_raw <= 24'h000000;
    repeat (3) @(negedge hclk);
    `CHK(temp_result, 24'hD63998)
    @(posedge hclk);
    ce <= 1'b1;
    repeat (2) @(negedge hclk);
    `CHK(temp_result, 24'hD53998)
    @(posedge hclk);
    wr(6'h37, 32'h007FFFFF);
    @(negedge hclk);
    `CHK(temp_result, 24'h7FFFFF)
    @(posedge hclk);
  endtask : t_regs
  task automatic t_dc;
    wr(6'h03, 32'h1);
    wr(6'h02, 32'h2);
    wr(6'h08, 32'h00400000);
    cal(4'h1, 3);
    rd_chk(6'h05, 32'h00FFFF00);
    rd_chk(6'h06, 32'h0);
    rd_chk(6'h01, 32'h1);
    wr(6'h01, 32'h3);
    rd_chk(6'h01, 32'h0);
    repeat (130) @(negedge hclk);
    `CHK(samp_corr[1], 24'h0)
    `CHK(samp_corr[2], 24'h004000)
    @(posedge hclk);
  endtask : t_dc
  task automatic t_ac;
    int n;
    wr(6'h0B, 32'h0);
    wr(6'h00, 32'h6);
    wr(6'h00, 32'h1);
    rd_chk(6'h00, 32'h6);
    wait_idle(n);
    rd_chk(6'h0B, 32'h40);
    wr(6'h0A, 32'h50);
    repeat (2) @(negedge hclk);
    `CHK(i_ms_corr[1], 24'h0000C0)
    `CHK(i_ms_corr[0], 24'h0)
    `CHK(samp_corr[2], 24'h004000)
    @(posedge hclk);
    wr(6'h00, 32'h4);
    `CHK(cal_busy, 1'b0)
    wr(6'h00, 32'hC);
    `CHK(cal_busy, 1'b0)
    // No settling and a zero count: one word averaged
    wr(6'h03, 32'h0);
    wr(6'h02, 32'h0);
    cal(4'h5, 1);
    rd_chk(6'h0A, 32'h0);
  endtask : t_ac
  task automatic t_gain;
    wr(6'h01, 32'h3);
    cal(4'h8, 0);
    rd_chk(6'h07, 32'h00800000);
    wr(6'h3F, 32'h00266666);
    cal(4'h9, 0);
    rd_chk(6'h08, 32'h00200000);
    wr(6'h3F, 32'h004CCCCC);
    cal(4'hA, 0);
    rd_chk(6'h09, 32'h00400000);
    rd_chk(6'h01, 32'h3);
  endtask : t_gain
  task automatic t_zx;
    wr(6'h18, 32'h00001000);
    repeat (520 * 60) @(posedge hclk);
    @(negedge hclk);
    `CHK(zx_en[0], 1'b1)
    `CHK(zx_en[2:1], 2'b10)
    `CHK(samp_corr[0], 24'h400000)
    @(posedge hclk);
  endtask : t_zx
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    raw_set = {24'h004000, 24'h000100, 24'h200000};
    rms_set = {24'h100000, 24'h4CCCCC, 24'h266666};
    ms_in = {24'h000100, 24'h000030};
    temp_raw = 24'h0;
    ce = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_dc();
    t_ac();
    t_gain();
    t_zx();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end
endmodule : mce_top_bench
`default_nettype wire
